/* File: src/fp_unit_consts.vh */
// Purpose: Shared constants of the float copy / multiply-subtract / multiply
//          unit: bus offsets, opcodes, status-control bit positions, codes.
// Assumes: Word-aligned AHB-Lite register map decoded on haddr[7:0].
// Notes:   Definitions only.
`ifndef FP_UNIT_CONSTS_VH
`define FP_UNIT_CONSTS_VH

// Register byte offsets
`define OFF_INSN        8'h00
`define OFF_STATUS_CTRL 8'h04
`define OFF_COND_ONE    8'h08
`define OFF_FREG_SEL    8'h0c
`define OFF_FREG_HI     8'h10
`define OFF_FREG_LO     8'h14
`define OFF_IRQ_STATUS  8'h18
`define OFF_IRQ_MASK    8'h1c

// Reset values
`define STATUS_CTRL_RST 32'h0000_0000
`define IRQ_MASK_RST    3'h0

// Opcodes
`define OP_DOUBLE       6'h3f
`define OP_SINGLE       6'h3b
`define XO_COPY         10'h048
`define XO_MSUB         5'h1c
`define XO_MUL          5'h19

// Status-control bit positions (bit 31 is the leftmost)
`define BIT_EXC_SUM     31
`define BIT_EN_SUM      30
`define BIT_INV_SUM     29
`define BIT_OVF         28
`define BIT_UNF         27
`define BIT_ZDIV        26
`define BIT_INEXACT     25
`define BIT_SNAN_INV    24
`define BIT_ISI_INV     23
`define BIT_IMZ_INV     20
`define BIT_ROUNDED_UP  18
`define BIT_FRAC_INX    17
`define CLASS_HI        16
`define CLASS_LO        12
`define BIT_INV_EN      7
`define BIT_OVF_EN      6
`define BIT_UNF_EN      5
`define BIT_ZDIV_EN     4
`define BIT_INX_EN      3
`define MODE_HI         1
`define MODE_LO         0
`define INV_BITS_MASK   32'h01f8_0700
`define EXC_BITS_MASK   32'h1ff8_0700

// Rounding modes
`define RMODE_NEAREST   2'h0
`define RMODE_ZERO      2'h1
`define RMODE_PLUS      2'h2
`define RMODE_MINUS     2'h3

// Result class codes
`define CLS_QNAN        5'h11
`define CLS_PINF        5'h05
`define CLS_NINF        5'h09
`define CLS_PZERO       5'h02
`define CLS_NZERO       5'h12
`define CLS_PNORM       5'h04
`define CLS_NNORM       5'h08

// Exponents (biased, double format) and magnitudes
`define EXP_BIAS        14'h03ff
`define DBL_EMAX        14'h07fe
`define DBL_EMIN        14'h0001
`define SGL_EMAX        14'h047e
`define SGL_EMIN        14'h0381
`define DEFAULT_QNAN    64'h7ff8_0000_0000_0000
`define INF_MAG         63'h7ff0_0000_0000_0000
`define DBL_MAX_MAG     63'h7fef_ffff_ffff_ffff
`define SGL_MAX_MAG     63'h47ef_ffff_e000_0000

// Interrupt event bits
`define EV_DONE         0
`define EV_ILLEGAL      1
`define EV_ENABLED_EXC  2

`endif

/* File: src/fp_move_mulsub_mul_decode.v */
// Purpose: Decodes and executes float register copy, fused multiply-subtract
//          and multiply (double and single) on an internal register file.
// Assumes: AHB-Lite single word transfers; one wait state per access.
// Notes:   An instruction written to the instruction register runs on the
//          next clock edge. Single results are held in double format.
// Contract
// - Copy writes source register unchanged to target
// - Copy is opcode 63, extended 72
// - Copy never alters status-control register
// - Record bit copies three summaries and overflow to field
// - Record bit clear leaves condition field alone
// - Double multiply-subtract is opcode 63, minor 28
// - Legacy alias shares multiply-subtract encoding exactly
// - Double: first times second minus subtrahend
// - Single multiply-subtract is opcode 59, minor 28
// - Product unrounded; only difference is rounded
// - Round by mode field, write target
// - Denormal operands prenormalized before operating
// - Class flags set unless enabled invalid
// - Multiply-subtract updates all listed status bits
// - Double multiply is opcode 63, minor 25
// - Single multiply is opcode 59, minor 25
// - Multiply adds exponents, multiplies significands, rounds
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fp_unit_consts.vh"

module fp_move_mulsub_mul_decode (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Interrupt
  output reg         irq
);

  function [6:0] lz110;
    input [109:0] v;
    integer       i;
    reg           hit;
    begin
      lz110 = 7'h00;
      hit   = 1'b0;
      for (i = 109; i >= 0; i = i - 1)
      begin
        if (!hit)
        begin
          if (v[i])
            hit = 1'b1;
          else
            lz110 = lz110 + 7'h01;
        end
      end
    end
  endfunction

  // Returns {exponent[13:0], significand[52:0]}
  function [66:0] unpack;
    input [63:0] x;
    reg   [52:0] m;
    reg   [6:0]  lz;
    begin
      if (x[62:52] == 11'h000)
      begin
        m      = {1'b0, x[51:0]};
        lz     = lz110({m, 57'h0});
        unpack = {14'h0001 - {7'h00, lz}, m << lz};
      end
      else
        unpack = {3'h0, x[62:52], 1'b1, x[51:0]};
    end
  endfunction

  // Right shift keeping lost bits as sticky in the lsb
  function [108:0] shr_st;
    input [108:0] v;
    input [13:0]  n;
    reg   [108:0] t;
    begin
      if (n > 14'h006c)
        shr_st = {108'h0, |v};
      else
      begin
        t      = v >> n;
        shr_st = {t[108:1], t[0] | ((t << n) != v)};
      end
    end
  endfunction

  // {nan, snan, inf, zero}
  function [3:0] cls;
    input [63:0] x;
    begin
      cls = {(&x[62:52]) & (|x[51:0]),
             (&x[62:52]) & (|x[51:0]) & ~x[51],
             (&x[62:52]) & ~(|x[51:0]),
             ~(|x[62:0])};
    end
  endfunction

  reg  [63:0] fregs [0:31];
  reg  [31:0] instr_word;
  reg         exec_pending;
  reg  [31:0] status_ctrl;
  reg  [3:0]  cond_one;
  reg  [4:0]  freg_sel;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg         dp_active;
  reg         dp_write;
  reg  [7:0]  dp_addr;

  wire        wr_en = dp_active & dp_write;
  wire [5:0]  op    = instr_word[31:26];
  wire [4:0]  t_idx = instr_word[25:21];
  wire [4:0]  a_idx = instr_word[20:16];
  wire [4:0]  b_idx = instr_word[15:11];
  wire [4:0]  c_idx = instr_word[10:6];
  wire [4:0]  minor = instr_word[5:1];
  wire [9:0]  ext10 = instr_word[10:1];
  wire        rec_bit = instr_word[0];
  wire [1:0]  rmode = status_ctrl[`MODE_HI:`MODE_LO];

  wire is_copy  = (op == `OP_DOUBLE) && (ext10 == `XO_COPY);
  wire arith_op = (op == `OP_DOUBLE) || (op == `OP_SINGLE);
  // one decode for all multiply-subtract names
  wire is_msub  = arith_op && (minor == `XO_MSUB);
  wire is_mul   = arith_op && (minor == `XO_MUL);
  wire single   = (op == `OP_SINGLE);
  wire legal    = is_copy | is_msub | is_mul;

  wire [63:0] va = fregs[a_idx];
  wire [63:0] vb = fregs[b_idx];
  wire [63:0] vc = fregs[c_idx];
  wire [3:0]  ca = cls(va);
  wire [3:0]  cb = cls(vb);
  wire [3:0]  cc = cls(vc);

  reg  [66:0]        ua, ub, uc;
  reg  [105:0]       prod;
  reg  [108:0]       x, y;
  reg  [109:0]       s, n;
  reg  signed [13:0] ep, eb, e, d, er, emax, emin;
  reg  [6:0]         lz;
  reg  [52:0]        kept;
  reg  [53:0]        kr;
  reg                sx, sy, rs, g, st, up, carry, b_used;
  reg  [63:0]        res;
  reg  [4:0]         rclass;
  reg                fl_ovf, fl_unf, fl_inx, fl_up;
  reg                v_snan, v_isi, v_imz, any_nan, prod_inf, to_inf;

  always @*
  begin
    b_used = is_msub;
    ua   = unpack(va);
    ub   = unpack(vb);
    uc   = unpack(vc);
    sx   = va[63] ^ vc[63];
    sy   = ~vb[63];
    prod = ua[52:0] * uc[52:0];
    ep   = ua[66:53] + uc[66:53] - `EXP_BIAS;
    eb   = ub[66:53];
    x    = (ca[0] | cc[0]) ? 109'h0 : {prod, 3'h0};
    // Unit bit at 107 for both terms, same weight as the product's
    y    = (~b_used | cb[0]) ? 109'h0 : {1'b0, ub[52:0], 55'h0};
    if (ca[0] | cc[0])
      ep = eb;
    if (~b_used | cb[0])
      eb = ep;
    d = ep - eb;
    if (d >= 14'sh0000)
    begin
      y = shr_st(y, d);
      e = ep;
    end
    else
    begin
      x = shr_st(x, 14'sh0000 - d);
      e = eb;
    end
    if (sx == sy)
    begin
      s  = {1'b0, x} + {1'b0, y};
      rs = sx;
    end
    else if (x >= y)
    begin
      s  = {1'b0, x} - {1'b0, y};
      rs = sx;
    end
    else
    begin
      s  = {1'b0, y} - {1'b0, x};
      rs = sy;
    end
    lz = lz110(s);
    n  = s << lz;
    er = e + 14'sh0002 - $signed({7'h00, lz});
    if (single)
    begin
      kept = {29'h0, n[109:86]};
      g    = n[85];
      st   = |n[84:0];
      emax = `SGL_EMAX;
      emin = `SGL_EMIN;
    end
    else
    begin
      kept = n[109:57];
      g    = n[56];
      st   = |n[55:0];
      emax = `DBL_EMAX;
      emin = `DBL_EMIN;
    end
    // single rounding of the final difference
    case (rmode)
      `RMODE_NEAREST: up = g & (st | kept[0]);
      `RMODE_ZERO:    up = 1'b0;
      `RMODE_PLUS:    up = (g | st) & ~rs;
      `RMODE_MINUS:   up = (g | st) & rs;
      default:        up = 1'b0;
    endcase
    kr    = {1'b0, kept} + {53'h0, up};
    carry = single ? kr[24] : kr[53];
    if (carry)
      er = er + 14'sh0001;
    to_inf = (rmode == `RMODE_NEAREST) || ((rmode == `RMODE_PLUS) && !rs)
             || ((rmode == `RMODE_MINUS) && rs);
    any_nan  = ca[3] | (b_used & cb[3]) | cc[3];
    prod_inf = ca[1] | cc[1];
    v_snan   = ca[2] | (b_used & cb[2]) | cc[2];
    v_imz    = ~any_nan & ((ca[1] & cc[0]) | (ca[0] & cc[1]));
    v_isi    = ~any_nan & ~v_imz & prod_inf & b_used & cb[1] & (sx != sy);
    fl_ovf   = 1'b0;
    fl_unf   = 1'b0;
    fl_inx   = 1'b0;
    fl_up    = 1'b0;
    if (any_nan)
    begin
      res    = ca[3] ? va : ((b_used & cb[3]) ? vb : vc);
      res[51] = 1'b1;
      rclass = `CLS_QNAN;
    end
    else if (v_imz | v_isi)
    begin
      res    = `DEFAULT_QNAN;
      rclass = `CLS_QNAN;
    end
    else if (prod_inf | (b_used & cb[1]))
    begin
      rs     = prod_inf ? sx : sy;
      res    = {rs, `INF_MAG};
      rclass = rs ? `CLS_NINF : `CLS_PINF;
    end
    else if (s == 110'h0)
    begin
      rs     = (sx == sy) ? sx : (rmode == `RMODE_MINUS);
      res    = {rs, 63'h0};
      rclass = rs ? `CLS_NZERO : `CLS_PZERO;
    end
    else if (er > emax)
    begin
      fl_ovf = 1'b1;
      fl_inx = 1'b1;
      fl_up  = to_inf;
      res    = {rs, to_inf ? `INF_MAG
                           : (single ? `SGL_MAX_MAG : `DBL_MAX_MAG)};
      rclass = to_inf ? (rs ? `CLS_NINF : `CLS_PINF)
                      : (rs ? `CLS_NNORM : `CLS_PNORM);
    end
    else if (er < emin)
    begin
      // Tiny results flush to signed zero; no denormal outputs
      fl_unf = 1'b1;
      fl_inx = 1'b1;
      res    = {rs, 63'h0};
      rclass = rs ? `CLS_NZERO : `CLS_PZERO;
    end
    else
    begin
      fl_inx = g | st;
      fl_up  = up;
      res    = single ? {rs, er[10:0], kr[22:0], 29'h0}
                      : {rs, er[10:0], kr[51:0]};
      rclass = rs ? `CLS_NNORM : `CLS_PNORM;
    end
  end

  reg [31:0] ns;
  reg        inv_now, suppress;

  always @*
  begin
    ns       = status_ctrl;
    inv_now  = v_snan | v_isi | v_imz;
    suppress = inv_now & status_ctrl[`BIT_INV_EN];
    ns[`BIT_SNAN_INV] = ns[`BIT_SNAN_INV] | v_snan;
    ns[`BIT_ISI_INV]  = ns[`BIT_ISI_INV] | v_isi;
    ns[`BIT_IMZ_INV]  = ns[`BIT_IMZ_INV] | v_imz;
    ns[`BIT_OVF]      = ns[`BIT_OVF] | (fl_ovf & ~suppress);
    ns[`BIT_UNF]      = ns[`BIT_UNF] | (fl_unf & ~suppress);
    ns[`BIT_INEXACT]  = ns[`BIT_INEXACT] | (fl_inx & ~suppress);
    ns[`BIT_ROUNDED_UP] = fl_up & ~suppress;
    ns[`BIT_FRAC_INX]   = fl_inx & ~suppress;
    // class kept when invalid is trapped
    if (!suppress)
      ns[`CLASS_HI:`CLASS_LO] = rclass;
    ns[`BIT_INV_SUM] = |(ns & `INV_BITS_MASK);
    ns[`BIT_EN_SUM]  = (ns[`BIT_INV_SUM] & ns[`BIT_INV_EN])
                     | (ns[`BIT_OVF] & ns[`BIT_OVF_EN])
                     | (ns[`BIT_UNF] & ns[`BIT_UNF_EN])
                     | (ns[`BIT_ZDIV] & ns[`BIT_ZDIV_EN])
                     | (ns[`BIT_INEXACT] & ns[`BIT_INX_EN]);
    ns[`BIT_EXC_SUM] = status_ctrl[`BIT_EXC_SUM]
                     | (|(ns & ~status_ctrl & `EXC_BITS_MASK));
  end

  // Register file write port; execution wins over the bus
  reg        freg_we;
  reg [4:0]  freg_waddr;
  reg [63:0] freg_wdata;
  wire [63:0] sel_word = fregs[freg_sel];

  always @*
  begin
    freg_we    = 1'b0;
    freg_waddr = t_idx;
    freg_wdata = res;
    if (exec_pending & is_copy)
    begin
      // copy source field to target unchanged
      freg_we    = 1'b1;
      freg_wdata = vb;
    end
    else if (exec_pending & (is_msub | is_mul))
      freg_we = ~suppress;
    else if (wr_en && (dp_addr == `OFF_FREG_HI))
    begin
      freg_we    = 1'b1;
      freg_waddr = freg_sel;
      freg_wdata = {hwdata, sel_word[31:0]};
    end
    else if (wr_en && (dp_addr == `OFF_FREG_LO))
    begin
      freg_we    = 1'b1;
      freg_waddr = freg_sel;
      freg_wdata = {sel_word[63:32], hwdata};
    end
  end

  // Data storage only, so no reset
  always @(posedge hclk)
  begin
    if (freg_we)
      fregs[freg_waddr] <= freg_wdata;
  end

  reg [31:0] rd_mux;
  reg [2:0]  ev;

  always @*
  begin
    case (dp_addr)
      `OFF_INSN:        rd_mux = instr_word;
      `OFF_STATUS_CTRL: rd_mux = status_ctrl;
      `OFF_COND_ONE:    rd_mux = {28'h0, cond_one};
      `OFF_FREG_SEL:    rd_mux = {27'h0, freg_sel};
      `OFF_FREG_HI:     rd_mux = sel_word[63:32];
      `OFF_FREG_LO:     rd_mux = sel_word[31:0];
      `OFF_IRQ_STATUS:  rd_mux = {29'h0, irq_status};
      `OFF_IRQ_MASK:    rd_mux = {29'h0, irq_mask};
      default:          rd_mux = 32'h0000_0000;
    endcase
    ev = 3'h0;
    if (exec_pending)
    begin
      ev[`EV_DONE]        = legal;
      ev[`EV_ILLEGAL]     = ~legal;
      ev[`EV_ENABLED_EXC] = (is_msub | is_mul) & ns[`BIT_EN_SUM]
                            & ~status_ctrl[`BIT_EN_SUM];
    end
  end

  // Bus slave: one wait state so read data leaves a flip-flop
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dp_active <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
    end
    else if (hready & hsel & htrans[1])
    begin
      dp_active <= 1'b1;
      dp_write  <= hwrite & (hsize == 3'h2);
      dp_addr   <= haddr[7:0];
      hreadyout <= 1'b0;
    end
    else if (dp_active)
    begin
      dp_active <= 1'b0;
      hreadyout <= 1'b1;
      // Word writes leave the last read data standing
      if (!dp_write)
        hrdata <= rd_mux;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_word   <= 32'h0000_0000;
      exec_pending <= 1'b0;
      status_ctrl  <= `STATUS_CTRL_RST;
      cond_one     <= 4'h0;
      freg_sel     <= 5'h00;
      irq_status   <= 3'h0;
      irq_mask     <= `IRQ_MASK_RST;
      irq          <= 1'b0;
    end
    else
    begin
      exec_pending <= wr_en && (dp_addr == `OFF_INSN);
      if (wr_en && (dp_addr == `OFF_INSN))
        instr_word <= hwdata;
      if (wr_en && (dp_addr == `OFF_FREG_SEL))
        freg_sel <= hwdata[4:0];
      if (wr_en && (dp_addr == `OFF_IRQ_MASK))
        irq_mask <= hwdata[2:0];
      // Event set wins over a same-cycle write-one clear
      if (wr_en && (dp_addr == `OFF_IRQ_STATUS))
        irq_status <= (irq_status & ~hwdata[2:0]) | ev;
      else
        irq_status <= irq_status | ev;
      irq <= |(irq_status & irq_mask);
      if (wr_en && (dp_addr == `OFF_STATUS_CTRL))
        status_ctrl <= hwdata;
      if (wr_en && (dp_addr == `OFF_COND_ONE))
        cond_one <= hwdata[3:0];
      if (exec_pending & (is_msub | is_mul))
        status_ctrl <= ns;
      // summaries taken after the status update
      // field held when record bit is clear
      if (exec_pending & legal & rec_bit)
        cond_one <= is_copy
                    ? status_ctrl[`BIT_EXC_SUM:`BIT_OVF]
                    : ns[`BIT_EXC_SUM:`BIT_OVF];
    end
  end

endmodule
`default_nettype wire

/* File: verif/fp_unit_sva.sv */
// Purpose: Port checks on the float unit bus and interrupt line.
// Assumes: One wait state per transfer; irq lags its cause by a clock.
// Notes:   Mask is mirrored from completed bus writes.
`timescale 1ns/1ps
`default_nettype none
`include "fp_unit_consts.vh"
module fp_unit_sva (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Interrupt
  input wire logic        irq
);
  logic       acc;
  logic       fin;
  logic       dph;
  logic       wr;
  logic [7:0] adr;
  logic [2:0] msk;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign acc = hsel && hready && htrans[1];
  assign fin = dph && hreadyout && wr;
  // Mirror lags the real mask by a clock, as irq does
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph <= 1'b0;
      wr  <= 1'b0;
      adr <= 8'h00;
      msk <= 3'h0;
    end
    else
    begin
      if (fin && adr == `OFF_IRQ_MASK)
        msk <= hwdata[2:0];
      if (acc)
      begin
        dph <= 1'b1;
        wr  <= hwrite;
        adr <= haddr[7:0];
      end
      else if (dph && hreadyout)
        dph <= 1'b0;
    end
  end
  property p_wait;
    acc |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_pulse;
    $fell(hreadyout) |=> hreadyout;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready low too long");
  property p_idle;
    !dph |-> hreadyout;
  endproperty
  a_idle: assert property (p_idle) else $error("ready low while idle");
  property p_okay;
    dph |-> !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_hold;
    $changed(hrdata) |-> $rose(hreadyout) && dph && !wr;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_mask0;
    msk == 3'h0 |-> !irq;
  endproperty
  a_mask0: assert property (p_mask0) else $error("irq with all masked");
  property p_done;
    fin && adr == `OFF_INSN && msk[0] |-> ##2 irq;
  endproperty
  a_done: assert property (p_done) else $error("no irq after insn");
  property p_fall;
    $fell(irq) |-> $past(fin) && ($past(adr) == `OFF_IRQ_STATUS
      || $past(adr) == `OFF_IRQ_MASK);
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell uncaused");
endmodule
bind fp_move_mulsub_mul_decode fp_unit_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

/* File: verif/ahb_master.sv */
// Purpose: Pipeline-side bus master issuing single word transfers.
// Assumes: Called right after a rising edge; hready is the slave's ready.
// Notes:   Write data is inverted once its phase ends.
`timescale 1ns/1ps
`default_nettype none
module ahb_master (
  // Clock
  input  wire logic        hclk,
  // Requests
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // Answers
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    begin
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Register-level test of copy, multiply-subtract and multiply.
// Assumes: Target register 6 for every instruction; word transfers only.
// Notes:   Expected results are worked by hand from the operands.
`timescale 1ns/1ps
`default_nettype none
`include "fp_unit_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  wire         hsel;
  wire  [31:0] haddr;
  wire  [1:0]  htrans;
  wire         hwrite;
  wire  [2:0]  hsize;
  wire  [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  int          n_fail = 0;
  int          checked = 0;
  always #50 hclk = ~hclk;
  ahb_master u_mst (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  fp_move_mulsub_mul_decode u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_mst.xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_mst.xfer(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask
  task automatic setf(input logic [4:0] i, input logic [63:0] v);
    wr(`OFF_FREG_SEL, {27'h0, i});
    wr(`OFF_FREG_HI, v[63:32]);
    wr(`OFF_FREG_LO, v[31:0]);
  endtask
  function automatic logic [31:0] fi(input logic [5:0] o,
    input logic [4:0] a, input logic [4:0] b, input logic [4:0] c,
    input logic [4:0] m, input logic r);
    fi = {o, 5'h06, a, b, c, m, r};
  endfunction
  // Run one instruction on a preset status, then check the outcome
  task automatic op(input logic [31:0] ins, input logic [31:0] s0,
    input logic [63:0] res, input logic [31:0] s1, input logic [3:0] cf);
    wr(`OFF_STATUS_CTRL, s0);
    wr(`OFF_INSN, ins);
    wr(`OFF_FREG_SEL, 32'h6);
    chk(`OFF_FREG_HI, res[63:32]);
    chk(`OFF_FREG_LO, res[31:0]);
    chk(`OFF_STATUS_CTRL, s1);
    chk(`OFF_COND_ONE, {28'h0, cf});
  endtask
  task automatic stop_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(`OFF_STATUS_CTRL, `STATUS_CTRL_RST);
    chk(`OFF_COND_ONE, 32'h0);
    chk(`OFF_IRQ_MASK, 32'h0);
    `CHK(hresp, 1'b0)
    wr(8'h20, 32'h5a5a_5a5a);
    chk(8'h20, 32'h0);
    setf(5'd4, 64'hc053_4000_0000_0000);
    setf(5'd5, 64'h400c_0000_0000_0000);
    setf(5'd7, 64'h3de2_6ab4_b33c_110a);
    setf(5'd25, 64'hffff_ffff_ffff_ffff);
    setf(5'd8, 64'h7ff0_0000_0000_0000);
    setf(5'd9, 64'h3ff0_0000_0000_0000);
    setf(5'd10, 64'h0);
    setf(5'd11, 64'h0008_0000_0000_0000);
    setf(5'd12, 64'h7e70_0000_0000_0000);
    setf(5'd13, 64'h7ff4_0000_0000_0000);
    op(fi(6'h3f, 5'h1f, 5'd25, 5'h02, 5'h08, 1'b1), 32'h9000_0003,
      64'hffff_ffff_ffff_ffff, 32'h9000_0003, 4'h9);
    op(fi(6'h3f, 5'h00, 5'd4, 5'h02, 5'h08, 1'b0), 32'h0,
      64'hc053_4000_0000_0000, 32'h0, 4'h9);
    op(fi(6'h3f, 5'd4, 5'd7, 5'd5, 5'h1c, 1'b1), 32'h0,
      64'hc070_d800_0000_0935, 32'h8202_8000, 4'h8);
    op(fi(6'h3f, 5'd4, 5'd7, 5'd5, 5'h1c, 1'b0), 32'h3,
      64'hc070_d800_0000_0936, 32'h8206_8003, 4'h8);
    op(fi(6'h3b, 5'd4, 5'd7, 5'd5, 5'h1c, 1'b0), 32'h0,
      64'hc070_d800_0000_0000, 32'h8202_8000, 4'h8);
    op(fi(6'h3f, 5'd4, 5'd7, 5'd5, 5'h1c, 1'b0), 32'h1,
      64'hc070_d800_0000_0935, 32'h8202_8001, 4'h8);
    op(fi(6'h3f, 5'd4, 5'd7, 5'd5, 5'h1c, 1'b0), 32'h2,
      64'hc070_d800_0000_0935, 32'h8202_8002, 4'h8);
    op(fi(6'h3f, 5'd4, 5'h15, 5'd5, 5'h19, 1'b0), 32'h0,
      64'hc070_d800_0000_0000, 32'h0000_8000, 4'h8);
    op(fi(6'h3b, 5'd4, 5'h00, 5'd5, 5'h19, 1'b1), 32'h0,
      64'hc070_d800_0000_0000, 32'h0000_8000, 4'h0);
    op(fi(6'h3f, 5'd11, 5'h00, 5'd12, 5'h19, 1'b0), 32'h0,
      64'h3e80_0000_0000_0000, 32'h0000_4000, 4'h0);
    op(fi(6'h3f, 5'd8, 5'h00, 5'd10, 5'h19, 1'b0), 32'h0,
      64'h7ff8_0000_0000_0000, 32'ha011_1000, 4'h0);
    op(fi(6'h3f, 5'd8, 5'd8, 5'd9, 5'h1c, 1'b0), 32'h0,
      64'h7ff8_0000_0000_0000, 32'ha081_1000, 4'h0);
    op(fi(6'h3f, 5'd13, 5'h00, 5'd9, 5'h19, 1'b0), 32'h0,
      64'h7ffc_0000_0000_0000, 32'ha101_1000, 4'h0);
    op(fi(6'h3f, 5'd8, 5'h00, 5'd10, 5'h19, 1'b0), 32'h80,
      64'h7ffc_0000_0000_0000, 32'he010_0080, 4'h0);
    // Unknown opcode leaves status alone and flags itself
    wr(`OFF_INSN, 32'h0);
    chk(`OFF_STATUS_CTRL, 32'he010_0080);
    chk(`OFF_IRQ_STATUS, 32'h7);
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_MASK, 32'h2);
    chk(`OFF_IRQ_MASK, 32'h2);
    `CHK(irq, 1'b1)
    wr(`OFF_IRQ_STATUS, 32'h7);
    chk(`OFF_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_MASK, 32'h1);
    op(fi(6'h3f, 5'h00, 5'd4, 5'h02, 5'h08, 1'b0), 32'h0,
      64'hc053_4000_0000_0000, 32'h0, 4'h0);
    `CHK(irq, 1'b1)
    wr(`OFF_IRQ_STATUS, 32'h1);
    chk(`OFF_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire
